/* File: inc/bcd_pkg.sv */
// Constants, types and decode helpers shared by the binary command decoder
`default_nettype none
package bcd_pkg;
	// ****************************************
	// Header and packet layout
	// ****************************************
	localparam logic [1:0] HDR_LAST = 2'h3;
	localparam logic [7:0] CMD_BEGIN = 8'ha0;
	localparam logic [7:0] CMD_HALT = 8'ha1;
	localparam logic [7:0] CMD_REL = 8'ha7;
	localparam logic [7:0] CMD_SERVO = 8'haa;
	localparam logic [7:0] COORD_OFF = 8'h00;
	localparam logic [7:0] COORD_ON = 8'h01;
	localparam logic [7:0] W_NONE = 8'h00;
	localparam logic [7:0] W_BYTE = 8'h01;
	localparam logic [7:0] W_WORD = 8'h02;
	localparam logic [7:0] W_LONG = 8'h04;
	localparam logic [7:0] W_REAL = 8'h06;
	localparam logic [7:0] RESP_OK = 8'h3a;
	localparam logic [7:0] RESP_BAD = 8'h3f;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_COUNT = 8'h08;
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam int unsigned CTRL_CLR_BIT = 1;
	localparam int unsigned STAT_BAD_BIT = 0;
	localparam int unsigned STAT_BUSY_BIT = 1;
	localparam int unsigned STAT_NUM_LSB = 8;
	localparam logic CTRL_EN_RESET = 1'b1;
	typedef enum {ST_HEAD, ST_DATA, ST_REPLY} bcd_state_t;
	// ****************************************
	// Decode helpers
	// ****************************************
	// Bytes per field, zero for no fields or an illegal code
	function automatic logic [2:0] width_bytes(input logic [7:0] w);
		unique case (w)
			W_BYTE: width_bytes = 3'h1;
			W_WORD: width_bytes = 3'h2;
			W_LONG: width_bytes = 3'h4;
			W_REAL: width_bytes = 3'h6;
			default: width_bytes = 3'h0;
		endcase
	endfunction : width_bytes
	function automatic logic width_ok(input logic [7:0] w);
		width_ok = (w == W_NONE) || (width_bytes(w) != 3'h0);
	endfunction : width_ok
	function automatic logic cmd_reserved(input logic [7:0] n);
		cmd_reserved = (n <= 8'h80) || (n >= 8'h9b && n <= 8'h9f)
			|| (n >= 8'hab && n <= 8'haf) || n == 8'hb6 || n == 8'hbb
			|| n == 8'hbc || n == 8'hc7 || (n >= 8'hd4 && n <= 8'hd7)
			|| (n >= 8'he2 && n <= 8'he4) || n >= 8'hef;
	endfunction : cmd_reserved
	// Whole-header check; the stop command may carry no fields
	function automatic logic hdr_bad(input logic [7:0] n, input logic [7:0] w,
			input logic [7:0] c);
		hdr_bad = cmd_reserved(n) || !width_ok(w) || c > COORD_ON
			|| (n == CMD_REL && c != COORD_OFF) || (n == CMD_HALT && w != W_NONE); // R11 R12
	endfunction : hdr_bad
	function automatic logic [3:0] popcount(input logic [7:0] m);
		popcount = 4'h0;
		for (int i = 0; i < 8; i++)
			popcount = popcount + {3'h0, m[i]};
	endfunction : popcount
	function automatic logic [2:0] lowest_idx(input logic [7:0] m);
		lowest_idx = 3'h0;
		for (int i = 7; i >= 0; i--)
			if (m[i])
				lowest_idx = 3'(i);
	endfunction : lowest_idx
endpackage : bcd_pkg
`default_nettype wire

/* File: inc/bcd_field_if.sv */
// Byte feed from the header decoder to the field assembler and its result
`default_nettype none
interface bcd_field_if;
	logic               byte_stb;
	logic [7:0]         byte_data;
	logic               first;
	logic               last;
	logic [7:0]         width;
	logic [2:0]         axis;
	logic               val_stb;
	logic [2:0]         val_axis;
	logic signed [31:0] val_int;
	logic [15:0]        val_frac;
	modport feed (output byte_stb, byte_data, first, last, width, axis,
		input val_stb, val_axis, val_int, val_frac);
	modport asm (input byte_stb, byte_data, first, last, width, axis,
		output val_stb, val_axis, val_int, val_frac);
endinterface : bcd_field_if
`default_nettype wire

/* File: verilog/bcd_field_asm.sv */
// Field assembler: big-endian bytes to a signed integer and fraction
`default_nettype none
module bcd_field_asm
(
	input  wire logic mclk,
	input  wire logic rst_b,
	bcd_field_if.asm  fif
);
	logic [47:0]        acc;
	logic [47:0]        next_acc;
	logic               next_stb;
	logic [2:0]         next_axis;
	logic signed [31:0] next_int;
	logic [15:0]        next_frac;

	// Shift each byte in, most significant first; sign-extend on the last
	always_comb
	begin
		next_acc = acc;
		next_stb = 1'b0;
		next_axis = fif.val_axis;
		next_int = fif.val_int;
		next_frac = fif.val_frac;
		if (fif.byte_stb)
		begin
			next_acc = fif.first ? {40'h0, fif.byte_data} : {acc[39:0], fif.byte_data}; // R9
			if (fif.last)
			begin
				next_stb = 1'b1;
				next_axis = fif.axis;
				next_frac = 16'h0;
				unique case (fif.width)
					bcd_pkg::W_BYTE: next_int = {{24{next_acc[7]}}, next_acc[7:0]}; // R9
					bcd_pkg::W_WORD: next_int = {{16{next_acc[15]}}, next_acc[15:0]}; // R9
					bcd_pkg::W_LONG: next_int = next_acc[31:0];
					default:
					begin
						// Real format: integer part first, fraction last
						next_int = next_acc[47:16]; // R5
						next_frac = next_acc[15:0]; // R5
					end
				endcase
			end
		end
	end

	// Result registers feed the top outputs directly
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			acc <= 48'h0;
			fif.val_stb <= 1'b0;
			fif.val_axis <= 3'h0;
			fif.val_int <= 32'h0;
			fif.val_frac <= 16'h0;
		end
		else
		begin
			acc <= next_acc;
			fif.val_stb <= next_stb;
			fif.val_axis <= next_axis;
			fif.val_int <= next_int;
			fif.val_frac <= next_frac;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	property p_word_sign;
		fif.byte_stb && fif.last && fif.width == bcd_pkg::W_WORD
			|=> fif.val_stb && fif.val_int[31:16] == {16{fif.val_int[15]}};
	endproperty
	a_word_sign: assert property (p_word_sign) else $error("word field not sign-extended"); // R9
	property p_real_frac;
		fif.byte_stb && fif.last && fif.width == bcd_pkg::W_REAL
			|=> fif.val_frac[7:0] == $past(fif.byte_data);
	endproperty
	a_real_frac: assert property (p_real_frac) else $error("fraction low byte lost"); // R5
	property p_real_seen;
		fif.val_stb && fif.val_frac != 16'h0;
	endproperty
	c_real_seen: cover property (p_real_seen);
endmodule : bcd_field_asm
`default_nettype wire

/* File: verilog/bcd_decoder.sv */
// Binary command decoder: header check, field split, reply and APB registers
`default_nettype none
// How it works
// R1 - A command opens with exactly four header bytes, then its fields.
// R2 - Header byte one is the command number, 80 to FF hex.
// R3 - Header byte two is the field width code: 00, 01, 02, 04 or 06.
// R4 - Width code 00 ends the command after its four header bytes.
// R5 - Width code 06 is four integer bytes then two fraction bytes.
// R6 - Header byte three equal to 01 selects the coordinated system.
// R7 - Header byte four is the axis mask, bit 0 axis A to bit 7 H.
// R8 - One field per set mask bit, given to axes in rising bit order.
// R9 - Fields are signed two's complement, most significant byte first.
// R10 - Command A7 is the relative move, fields give axis distances.
// R11 - The relative move must carry coordinated byte 00.
// R12 - Command A1 halts the masked axes and carries no fields.
// R13 - Halt with coordinated byte 01 also halts the coordinated system.
// R14 - Binary commands are taken only from the host link.
// R15 - Reply colon for a valid command, question mark for an invalid one.
// R16 - Reserved command numbers and unknown width codes are rejected.
// R17 - Packet length is four plus width times set mask bits.
module bcd_decoder
(
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_from_host,
	output logic             rx_ready,
	output logic             resp_valid,
	output logic [7:0]       resp_data,
	output logic             cmd_valid,
	output logic [7:0]       cmd_num,
	output logic [7:0]       cmd_width,
	output logic             cmd_coord,
	output logic [7:0]       cmd_mask,
	output logic             relative_move,
	output logic             begin_motion,
	output logic             servo_enable,
	output logic [7:0]       halt_motion,
	output logic             halt_coordinated,
	output logic             field_valid,
	output logic [2:0]       field_axis,
	output logic [31:0]      field_int,
	output logic [15:0]      field_frac,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);
	bcd_pkg::bcd_state_t state;
	bcd_pkg::bcd_state_t next_state;
	logic [1:0]  hdr_cnt, next_hdr_cnt;
	logic [7:0]  num, next_num;
	logic [7:0]  width, next_width;
	logic [7:0]  coord, next_coord;
	logic [7:0]  mask, next_mask;
	logic [7:0]  rem_mask, next_rem_mask;
	logic [2:0]  fb_cnt, next_fb_cnt;
	logic [5:0]  data_left, next_data_left;
	logic        bad, next_bad;
	logic        last_bad, next_last_bad;
	logic [7:0]  last_num, next_last_num;
	logic [15:0] ok_cnt, next_ok_cnt;
	logic [15:0] bad_cnt, next_bad_cnt;
	logic        next_rx_ready, next_resp_valid, next_cmd_valid;
	logic        next_rel, next_begin, next_servo, next_halt_coord;
	logic [7:0]  next_resp_data, next_halt;
	logic        ctrl_en, next_ctrl_en, clr, next_clr;
	logic        next_pready, next_pslverr, acc, last_byte;
	logic [31:0] next_prdata, stat_word;

	bcd_field_if fif ();

	bcd_field_asm u_asm
	(
		.mclk  (mclk),
		.rst_b (rst_b),
		.fif   (fif)
	);

	// ****************************************
	// Byte feed to the assembler
	// ****************************************
	assign acc = rx_valid && rx_ready;
	assign last_byte = fb_cnt == bcd_pkg::width_bytes(width) - 3'h1;
	// Fields after the packet is marked bad never reach the motion engine
	assign fif.byte_stb = acc && state == bcd_pkg::ST_DATA && !bad && rx_from_host;
	assign fif.byte_data = rx_data;
	assign fif.first = fb_cnt == 3'h0;
	assign fif.last = last_byte;
	assign fif.width = width;
	assign fif.axis = bcd_pkg::lowest_idx(rem_mask); // R8
	assign field_valid = fif.val_stb;
	assign field_axis = fif.val_axis;
	assign field_int = fif.val_int;
	assign field_frac = fif.val_frac;

	// ****************************************
	// Packet decoder
	// ****************************************
	always_comb
	begin
		next_state = state;
		{next_hdr_cnt, next_fb_cnt, next_data_left, next_bad}
			= {hdr_cnt, fb_cnt, data_left, bad};
		{next_num, next_width, next_coord, next_mask, next_rem_mask}
			= {num, width, coord, mask, rem_mask};
		{next_last_bad, next_last_num} = {last_bad, last_num};
		next_ok_cnt = clr ? 16'h0 : ok_cnt;
		next_bad_cnt = clr ? 16'h0 : bad_cnt;
		next_resp_valid = 1'b0;
		next_resp_data = resp_data;
		next_cmd_valid = 1'b0;
		{next_rel, next_begin, next_servo, next_halt, next_halt_coord} = 12'h0;
		// Bytes from the stored program poison the packet
		if (acc && !rx_from_host)
			next_bad = 1'b1; // R14
		unique case (state)
			bcd_pkg::ST_HEAD:
			begin
				if (acc)
				begin
					next_hdr_cnt = hdr_cnt + 2'h1; // R1
					unique case (hdr_cnt)
						2'h0: next_num = rx_data; // R2
						2'h1: next_width = rx_data; // R3
						2'h2: next_coord = rx_data; // R6
						2'h3:
						begin
							next_mask = rx_data; // R7
							next_rem_mask = rx_data;
							next_fb_cnt = 3'h0;
							next_data_left = 6'(bcd_pkg::width_bytes(width)
								* bcd_pkg::popcount(rx_data)); // R17
							if (bcd_pkg::hdr_bad(num, width, coord))
								next_bad = 1'b1; // R16
							// No fields: complete at the header
							next_state = (next_data_left == 6'h0) ? bcd_pkg::ST_REPLY
								: bcd_pkg::ST_DATA; // R4
						end
					endcase
				end
			end
			bcd_pkg::ST_DATA:
			begin
				if (acc)
				begin
					next_data_left = data_left - 6'h1; // R17
					if (last_byte)
					begin
						// Retire the lowest axis, next field goes to the next bit
						next_fb_cnt = 3'h0;
						next_rem_mask = rem_mask & (rem_mask - 8'h01); // R8
					end
					else
						next_fb_cnt = fb_cnt + 3'h1;
					if (data_left == 6'h1)
						next_state = bcd_pkg::ST_REPLY; // R17
				end
			end
			bcd_pkg::ST_REPLY:
			begin
				next_state = bcd_pkg::ST_HEAD;
				next_bad = 1'b0;
				next_resp_valid = 1'b1;
				next_resp_data = bad ? bcd_pkg::RESP_BAD : bcd_pkg::RESP_OK; // R15
				next_last_bad = bad;
				next_last_num = num;
				if (bad)
					next_bad_cnt = next_bad_cnt + 16'h1;
				else
				begin
					next_ok_cnt = next_ok_cnt + 16'h1;
					next_cmd_valid = 1'b1;
					next_rel = num == bcd_pkg::CMD_REL; // R10
					next_begin = num == bcd_pkg::CMD_BEGIN;
					next_servo = num == bcd_pkg::CMD_SERVO;
					next_halt = (num == bcd_pkg::CMD_HALT) ? mask : 8'h00; // R12
					next_halt_coord = num == bcd_pkg::CMD_HALT
						&& coord == bcd_pkg::COORD_ON; // R13
				end
			end
		endcase
		// Stall the link while the reply is issued
		next_rx_ready = ctrl_en && next_state != bcd_pkg::ST_REPLY;
	end

	// Decoder registers
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			state <= bcd_pkg::ST_HEAD;
			{hdr_cnt, fb_cnt, data_left, bad} <= 12'h0;
			{num, width, coord, mask, rem_mask} <= 40'h0;
			{last_bad, last_num, ok_cnt, bad_cnt} <= 41'h0;
			{rx_ready, resp_valid, resp_data, cmd_valid} <= 11'h0;
			{cmd_num, cmd_width, cmd_coord, cmd_mask} <= 25'h0;
			{relative_move, begin_motion, servo_enable, halt_motion, halt_coordinated} <= 12'h0;
		end
		else
		begin
			state <= next_state;
			{hdr_cnt, fb_cnt, data_left, bad}
				<= {next_hdr_cnt, next_fb_cnt, next_data_left, next_bad};
			{num, width, coord, mask, rem_mask}
				<= {next_num, next_width, next_coord, next_mask, next_rem_mask};
			{last_bad, last_num, ok_cnt, bad_cnt}
				<= {next_last_bad, next_last_num, next_ok_cnt, next_bad_cnt};
			{rx_ready, resp_valid, resp_data, cmd_valid}
				<= {next_rx_ready, next_resp_valid, next_resp_data, next_cmd_valid};
			if (next_cmd_valid)
			begin
				cmd_num <= num;
				cmd_width <= width;
				cmd_coord <= coord == bcd_pkg::COORD_ON; // R6
				cmd_mask <= mask;
			end
			{relative_move, begin_motion, servo_enable, halt_motion, halt_coordinated}
				<= {next_rel, next_begin, next_servo, next_halt, next_halt_coord};
		end
	end

	// ****************************************
	// APB slave, one wait state
	// ****************************************
	always_comb
	begin
		stat_word = 32'h0;
		stat_word[bcd_pkg::STAT_BAD_BIT] = last_bad;
		stat_word[bcd_pkg::STAT_BUSY_BIT] = state != bcd_pkg::ST_HEAD || hdr_cnt != 2'h0;
		stat_word[bcd_pkg::STAT_NUM_LSB +: 8] = last_num;
		next_ctrl_en = ctrl_en;
		next_clr = 1'b0;
		next_pready = 1'b0;
		next_prdata = prdata;
		next_pslverr = 1'b0;
		if (psel && penable && !pready)
		begin
			next_pready = 1'b1;
			unique case (paddr)
				bcd_pkg::REG_CTRL: next_prdata = {31'h0, ctrl_en};
				bcd_pkg::REG_STAT: next_prdata = stat_word;
				bcd_pkg::REG_COUNT: next_prdata = {bad_cnt, ok_cnt};
				default:
				begin
					next_prdata = 32'h0;
					next_pslverr = 1'b1;
				end
			endcase
		end
		// Writes land only on the edge that completes the transfer
		if (psel && penable && pready && pwrite && paddr == bcd_pkg::REG_CTRL)
		begin
			next_ctrl_en = pwdata[bcd_pkg::CTRL_EN_BIT];
			next_clr = pwdata[bcd_pkg::CTRL_CLR_BIT];
		end
	end

	// Register bus flops
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			ctrl_en <= bcd_pkg::CTRL_EN_RESET;
			{clr, pready, prdata, pslverr} <= 35'h0;
		end
		else
		begin
			ctrl_en <= next_ctrl_en;
			{clr, pready, prdata, pslverr} <= {next_clr, next_pready, next_prdata, next_pslverr};
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	property p_no_data;
		acc && state == bcd_pkg::ST_HEAD && hdr_cnt == bcd_pkg::HDR_LAST
			&& width == bcd_pkg::W_NONE |=> state == bcd_pkg::ST_REPLY ##1 resp_valid;
	endproperty
	a_no_data: assert property (p_no_data) else $error("fieldless command not closed"); // R4
	property p_len;
		acc && state == bcd_pkg::ST_DATA && data_left == 6'h1
			|=> state == bcd_pkg::ST_REPLY ##1 resp_valid && state == bcd_pkg::ST_HEAD;
	endproperty
	a_len: assert property (p_len) else $error("packet length not honoured"); // R17
	property p_num_range;
		cmd_valid |-> cmd_num[7] && !bcd_pkg::cmd_reserved(cmd_num);
	endproperty
	a_num_range: assert property (p_num_range) else $error("bad command number accepted"); // R2
	property p_width;
		cmd_valid |-> bcd_pkg::width_ok(cmd_width);
	endproperty
	a_width: assert property (p_width) else $error("bad width code accepted"); // R16
	property p_rel_coord;
		relative_move |-> !cmd_coord && cmd_num == bcd_pkg::CMD_REL;
	endproperty
	a_rel_coord: assert property (p_rel_coord) else $error("relative move coordinated"); // R11
	property p_halt;
		halt_motion != 8'h00 |-> cmd_num == bcd_pkg::CMD_HALT && halt_motion == cmd_mask
			&& cmd_width == bcd_pkg::W_NONE;
	endproperty
	a_halt: assert property (p_halt) else $error("halt axes wrong"); // R12
	property p_halt_coord;
		cmd_valid && cmd_num == bcd_pkg::CMD_HALT |-> halt_coordinated == cmd_coord;
	endproperty
	a_halt_coord: assert property (p_halt_coord) else $error("coordinated halt wrong"); // R13
	property p_reply;
		resp_valid |-> cmd_valid == (resp_data == bcd_pkg::RESP_OK)
			&& (resp_data == bcd_pkg::RESP_OK || resp_data == bcd_pkg::RESP_BAD);
	endproperty
	a_reply: assert property (p_reply) else $error("reply does not match verdict"); // R15
	property p_program_src;
		acc && !rx_from_host |=> bad && !fif.val_stb;
	endproperty
	a_program_src: assert property (p_program_src) else $error("program byte accepted"); // R14
	c_rel: cover property (relative_move && cmd_mask == 8'h05);
	c_halt_coord: cover property (halt_coordinated && halt_motion != 8'h00);
	c_bad: cover property (resp_valid && resp_data == bcd_pkg::RESP_BAD);
endmodule : bcd_decoder
`default_nettype wire

/* File: tb/bcd_host_model.sv */
// Host link model: offers command bytes one by one and waits for the decoder
`default_nettype none
module bcd_host_model
(
	input  wire logic mclk,
	input  wire logic rx_ready,
	output logic      rx_valid,
	output logic [7:0] rx_data,
	output logic      rx_from_host
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		rx_valid = 1'b0;
		rx_data = 8'h5a;
		rx_from_host = 1'b1;
	end
	// Header then fields, each byte held until the decoder takes it
	task automatic send(input logic [7:0] b[$], input logic host);
		for (int i = 0; i < b.size(); i++)
		begin
			rx_valid <= 1'b1;
			rx_data <= b[i];
			rx_from_host <= host;
			do
				@(posedge mclk);
			while (rx_ready !== 1'b1);
		end
		// Released line shows junk, never the last byte again
		rx_valid <= 1'b0;
		rx_data <= ~b[b.size() - 1];
	endtask : send
endmodule : bcd_host_model
`default_nettype wire

/* File: tb/bcd_decoder_bench.sv */
// Self-checking bench for the binary command decoder
`default_nettype none
module bcd_decoder_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [79:0] b; logic [3:0] n; logic ok;} bcd_row_t;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic rx_valid, rx_from_host, rx_ready, resp_valid, cmd_valid, cmd_coord;
	logic [7:0] rx_data, resp_data, cmd_num, cmd_width, cmd_mask, halt_motion;
	logic relative_move, begin_motion, servo_enable, halt_coordinated;
	logic field_valid, pready, pslverr;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [2:0] field_axis;
	logic [31:0] field_int, prdata, rd;
	logic [15:0] field_frac;
	logic [50:0] fq[$];
	logic [20:0] rq[$];
	logic err;
	int err_count = 0;
	int n_compared = 0;
	int cyc = 0;
	// Packets in link order; bad ones still send their full length
	bcd_row_t rows[14] = '{
		'{80'ha7020005_03e8fe0c_0000, 4'd8, 1'b1},
		'{80'ha1000107_00000000_0000, 4'd4, 1'b1},
		'{80'ha1000080_00000000_0000, 4'd4, 1'b1},
		'{80'ha00000ff_00000000_0000, 4'd4, 1'b1},
		'{80'haa000001_00000000_0000, 4'd4, 1'b1},
		'{80'ha7010081_7f800000_0000, 4'd6, 1'b1},
		'{80'ha7040002_fffffffe_0000, 4'd8, 1'b1},
		'{80'ha6060001_00000005_8000, 4'd10, 1'b1},
		'{80'h80000000_00000000_0000, 4'd4, 1'b0},
		'{80'ha7030000_00000000_0000, 4'd4, 1'b0},
		'{80'ha7020101_12340000_0000, 4'd6, 1'b0},
		'{80'ha2000100_00000000_0000, 4'd4, 1'b1},
		'{80'ha1010001_55000000_0000, 4'd5, 1'b0},
		'{80'hef000000_00000000_0000, 4'd4, 1'b0}};
	bcd_decoder dut_u (.mclk(mclk), .rst_b(rst_b), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_from_host(rx_from_host), .rx_ready(rx_ready), .resp_valid(resp_valid),
		.resp_data(resp_data), .cmd_valid(cmd_valid), .cmd_num(cmd_num),
		.cmd_width(cmd_width), .cmd_coord(cmd_coord), .cmd_mask(cmd_mask),
		.relative_move(relative_move), .begin_motion(begin_motion),
		.servo_enable(servo_enable), .halt_motion(halt_motion),
		.halt_coordinated(halt_coordinated), .field_valid(field_valid),
		.field_axis(field_axis), .field_int(field_int), .field_frac(field_frac),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	bcd_host_model host_u (.mclk(mclk), .rx_ready(rx_ready), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_from_host(rx_from_host));
	// ****************************************
	// Clock, watchdog and output capture
	// ****************************************
	always #2.5 mclk = ~mclk;
	// Pulses live one cycle, so capture them at every edge
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			err_count++;
			stop_test();
		end
		if (rst_b && field_valid === 1'b1)
			fq.push_back({field_axis, field_int, field_frac});
		if (rst_b && resp_valid === 1'b1)
			rq.push_back({cmd_valid, relative_move, begin_motion, servo_enable,
				halt_coordinated, halt_motion, resp_data});
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	// Setup then access, held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// Only the watchdog ends a hung wait
		do
			@(posedge mclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb
	// Send one packet, then check reply, strobes and every field
	task automatic run_row(input bcd_row_t r, input logic host);
		logic [7:0] q[$];
		logic [7:0] b[10];
		logic [20:0] got, exp;
		logic [50:0] f;
		logic signed [31:0] v;
		logic ok;
		int n, pos, wb;
		for (int k = 0; k < 10; k++)
			b[k] = r.b[79 - 8 * k -: 8];
		for (int k = 0; k < int'(r.n); k++)
			q.push_back(b[k]);
		host_u.send(q, host);
		n = 0;
		while (rq.size() == 0 && n < 60)
		begin
			@(posedge mclk);
			n++;
		end
		ok = r.ok && host;
		got = (rq.size() > 0) ? rq.pop_front() : 21'h0;
		exp = ok ? {1'b1, b[0] == bcd_pkg::CMD_REL, b[0] == bcd_pkg::CMD_BEGIN,
			b[0] == bcd_pkg::CMD_SERVO, b[0] == bcd_pkg::CMD_HALT && b[2] == 8'h01,
			(b[0] == bcd_pkg::CMD_HALT) ? b[3] : 8'h00, bcd_pkg::RESP_OK}
			: {13'h0, bcd_pkg::RESP_BAD};
		chk(32'(got), 32'(exp), "reply");
		if (ok)
		begin
			chk({7'h0, cmd_coord, cmd_width, cmd_mask, cmd_num},
				{7'h0, b[2][0], b[1], b[3], b[0]}, "header");
			wb = (b[1] == 8'h06) ? 6 : int'(b[1]);
			pos = 4;
			for (int ai = 0; ai < 8; ai++)
				if (b[3][ai] && wb != 0)
				begin
					f = (fq.size() > 0) ? fq.pop_front() : 51'h0;
					v = {32{b[pos][7]}};
					for (int k = 0; k < ((wb == 6) ? 4 : wb); k++)
						v = {v[23:0], b[pos + k]};
					chk(32'(f[50:48]), ai, "axis");
					chk(f[47:16], v, "value");
					chk(32'(f[15:0]), (wb == 6) ? {16'h0, b[pos + 4], b[pos + 5]} : 0,
						"fraction");
					pos += wb;
				end
		end
		else
			chk(32'(fq.size()), 32'h0, "fields of bad packet");
		fq.delete();
	endtask : run_row
	task automatic stop_test();
		$display("mismatches %0d of %0d compared", err_count, n_compared);
		if (err_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		repeat (10) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		@(posedge mclk);
		chk({23'h0, rx_ready, resp_data}, 32'h100, "reset state");
		apb(1'b0, bcd_pkg::REG_CTRL, 32'h0);
		chk(rd, 32'h1, "ctrl reset");
		foreach (rows[i])
			run_row(rows[i], 1'b1);
		apb(1'b0, bcd_pkg::REG_COUNT, 32'h0);
		chk(rd, {16'd5, 16'd9}, "counts");
		run_row(rows[3], 1'b0);
		apb(1'b0, bcd_pkg::REG_STAT, 32'h0);
		chk(rd, 32'ha001, "status");
		apb(1'b0, 8'h0c, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped error");
		// Disabled decoder must refuse bytes until enabled again
		apb(1'b1, bcd_pkg::REG_CTRL, 32'h0);
		@(posedge mclk);
		chk({31'h0, rx_ready}, 32'h0, "disabled ready");
		apb(1'b1, bcd_pkg::REG_CTRL, 32'h3);
		apb(1'b0, bcd_pkg::REG_COUNT, 32'h0);
		chk(rd, 32'h0, "counts cleared");
		run_row(rows[0], 1'b1);
		stop_test();
	end
endmodule : bcd_decoder_bench
`default_nettype wire
